/* File: core/mip_core.sv */
// interrupt flag, enable and priority logic with axi4-lite registers
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps

// What this block does
// - a source event sets its flag; all flags are readable
// - writing one to a flag bit clears it
// - reset clears every flag
// - a request stays pending while its flag stays set
// - key flags set on rising or falling pin edge per edge-select bit
// - timer n underflow at bit 2n, match at 2n+1, two flag bytes
// - serial channel flags: error, receive done, transmit done
// - time-base flags set on falling edge of their tick signals
// - one readable enable bit per flag, one enables
// - reset clears every enable bit
// - enable bits share flag bit positions, one byte per group
// - two-bit priority per system; level 0 raises no request
// - priority fields placed across three priority bytes
// - equal levels resolved by fixed default source order
// - order inside a system is fixed in hardware
// - reset clears all priority fields to level 0
// - acceptance needs flag, enable and level above mask
module mip_core (
	// clock, reset, enable
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// event sources
	input  wire logic [7:0]  key_pin_i,
	input  wire logic [15:0] timer_event_i,
	input  wire logic [5:0]  serial_event_i,
	input  wire logic [6:0]  timebase_tick_i,
	input  wire logic        watchdog_i,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [17:0] s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [17:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// cpu request side
	output logic [1:0]       irq_level_o,
	output logic [5:0]       irq_source_o,
	output logic             nmi_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]       key_sync1;
		logic [7:0]       key_sync2;
		logic [7:0]       key_prev;
		logic [6:0]       tb_sync1;
		logic [6:0]       tb_sync2;
		logic [6:0]       tb_prev;
		logic             wd_sync1;
		logic             wd_sync2;
		logic [36:0]      flags;
		logic [36:0]      enables;
		logic [7:0]       key_edge;
		logic [7:0]       prio_a;
		logic [7:0]       prio_b;
		logic [7:0]       prio_c;
		mip_pkg::mip_bus_t wst;
		mip_pkg::mip_bus_t rst;
		logic             aw_got;
		logic             w_got;
		logic [15:0]      waddr;
		logic [31:0]      wdata;
		logic             wbyte;
		logic [1:0]       bresp;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [1:0]       level;
		logic [5:0]       source;
		logic             nmi;
		logic             aw_rdy;
		logic             w_rdy;
		logic             bv;
		logic             ar_rdy;
		logic             rv;
	} mip_state_t;

	mip_state_t s_q;
	mip_state_t s_d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [36:0] set_ev;
	logic [36:0] pend;
	logic [1:0]  src_lvl [mip_pkg::NUM_SRC];
	logic [7:0]  key_rise;
	logic [7:0]  key_fall;
	logic [1:0]  best_lvl;
	logic [5:0]  best_src;

	// edge detection on synchronised pins
	assign key_rise = s_q.key_sync2 & ~s_q.key_prev;
	assign key_fall = ~s_q.key_sync2 & s_q.key_prev;

	// event vector in default order: keys 7..0, timers 0-3, serial 0,
	// time base, timers 4-7, serial 1
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_key
			// edge select one means rising edge
			assign set_ev[mip_pkg::SRC_KEY + 7 - g] = s_q.key_edge[g] ?
				key_rise[g] : key_fall[g];
		end
		for (g = 0; g < 8; g++) begin : g_tim
			assign set_ev[mip_pkg::SRC_TLO + g] = timer_event_i[g];
			assign set_ev[mip_pkg::SRC_THI + g] = timer_event_i[8 + g];
		end
		for (g = 0; g < 3; g++) begin : g_ser
			assign set_ev[mip_pkg::SRC_SER0 + g] = serial_event_i[2 - g];
			assign set_ev[mip_pkg::SRC_SER1 + g] = serial_event_i[5 - g];
		end
		for (g = 0; g < 7; g++) begin : g_tb
			// falling edge of each tick
			assign set_ev[mip_pkg::SRC_TB + g] =
				s_q.tb_prev[6 - g] & ~s_q.tb_sync2[6 - g];
		end
		for (g = 0; g < mip_pkg::NUM_SRC; g++) begin : g_lvl
			// system level per source, order within system fixed
			if (g < mip_pkg::SRC_TLO)
				assign src_lvl[g] = s_q.prio_a[7:6];
			else if (g < mip_pkg::SRC_TLO + 4)
				assign src_lvl[g] = s_q.prio_b[3:2];
			else if (g < mip_pkg::SRC_SER0)
				assign src_lvl[g] = s_q.prio_b[5:4];
			else if (g < mip_pkg::SRC_TB)
				assign src_lvl[g] = s_q.prio_a[5:4];
			else if (g < mip_pkg::SRC_TB + 3)
				assign src_lvl[g] = s_q.prio_a[3:2];
			else if (g < mip_pkg::SRC_THI)
				assign src_lvl[g] = s_q.prio_a[1:0];
			else if (g < mip_pkg::SRC_THI + 4)
				assign src_lvl[g] = s_q.prio_c[1:0];
			else if (g < mip_pkg::SRC_SER1)
				assign src_lvl[g] = s_q.prio_c[3:2];
			else
				assign src_lvl[g] = s_q.prio_b[1:0];
		end
	endgenerate

	// pending while flag and enable both set
	assign pend = s_q.flags & s_q.enables;

	// highest level wins, lower index wins on ties
	always_comb begin
		best_lvl = 2'h0;
		best_src = mip_pkg::SRC_NONE;
		for (int i = mip_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pend[i] && src_lvl[i] != 2'h0 && src_lvl[i] >= best_lvl) begin
				best_lvl = src_lvl[i];
				best_src = 6'(i);
			end
		end
	end

	// byte view of flag or enable vector by register address
	function automatic logic [7:0] grp(input logic [36:0] v,
		input logic [15:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == mip_pkg::ADDR_KEY_FLG || a == mip_pkg::ADDR_KEY_EN) begin
			for (int k = 0; k < 8; k++)
				r[k] = v[mip_pkg::SRC_KEY + 7 - k];
		end else if (a == mip_pkg::ADDR_TLO_FLG || a == mip_pkg::ADDR_TLO_EN) begin
			r = v[mip_pkg::SRC_TLO +: 8];
		end else if (a == mip_pkg::ADDR_THI_FLG || a == mip_pkg::ADDR_THI_EN) begin
			r = v[mip_pkg::SRC_THI +: 8];
		end else if (a == mip_pkg::ADDR_SER_FLG || a == mip_pkg::ADDR_SER_EN) begin
			for (int k = 0; k < 3; k++) begin
				r[k] = v[mip_pkg::SRC_SER0 + 2 - k];
				r[k + 3] = v[mip_pkg::SRC_SER1 + 2 - k];
			end
		end else if (a == mip_pkg::ADDR_TB_FLG || a == mip_pkg::ADDR_TB_EN) begin
			for (int k = 0; k < 7; k++)
				r[k] = v[mip_pkg::SRC_TB + 6 - k];
		end
		return r;
	endfunction

	// scatter a register byte back into vector positions of one group
	function automatic logic [36:0] spread(input logic [7:0] b,
		input logic [15:0] a);
		logic [36:0] r;
		r = '0;
		for (int i = 0; i < mip_pkg::NUM_SRC; i++)
			for (int k = 0; k < 8; k++)
				if (grp(37'(1) << i, a) == (8'h01 << k) && b[k])
					r[i] = 1'b1;
		return r;
	endfunction

	// read mux
	function automatic logic [8:0] rd_byte(input mip_state_t s,
		input logic [15:0] a);
		logic [8:0] r;
		r = {1'b0, 8'h00};
		if (a == mip_pkg::ADDR_PRIO_A)
			r = {1'b0, s.prio_a};
		else if (a == mip_pkg::ADDR_PRIO_B)
			r = {1'b0, s.prio_b};
		else if (a == mip_pkg::ADDR_PRIO_C)
			r = {1'b0, s.prio_c};
		else if (a == mip_pkg::ADDR_KEY_EDGE)
			r = {1'b0, s.key_edge};
		else if (a == mip_pkg::ADDR_TB_EN || a == mip_pkg::ADDR_SER_EN ||
			a == mip_pkg::ADDR_KEY_EN || a == mip_pkg::ADDR_TLO_EN ||
			a == mip_pkg::ADDR_THI_EN)
			r = {1'b0, grp(s.enables, a)};
		else if (a == mip_pkg::ADDR_TB_FLG || a == mip_pkg::ADDR_SER_FLG ||
			a == mip_pkg::ADDR_KEY_FLG || a == mip_pkg::ADDR_TLO_FLG ||
			a == mip_pkg::ADDR_THI_FLG)
			r = {1'b0, grp(s.flags, a)};
		else
			r = {1'b1, 8'h00};
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [8:0]  rb;
	logic [7:0]  wb;
	logic [36:0] clr;
	logic        do_wr;

	always_comb begin
		s_d = s_q;
		clr = '0;
		wb = s_q.wdata[7:0];
		do_wr = 1'b0;
		rb = rd_byte(s_q, s_axi_araddr[17:2]); // word index
		// input synchronisers and edge history
		s_d.key_sync1 = key_pin_i;
		s_d.key_sync2 = s_q.key_sync1;
		s_d.key_prev  = s_q.key_sync2;
		s_d.tb_sync1  = timebase_tick_i;
		s_d.tb_sync2  = s_q.tb_sync1;
		s_d.tb_prev   = s_q.tb_sync2;
		s_d.wd_sync1  = watchdog_i;
		s_d.wd_sync2  = s_q.wd_sync1;
		// write channel capture, either order
		if (s_q.wst == mip_pkg::MIP_IDLE) begin
			if (s_axi_awvalid && s_q.aw_rdy) begin
				s_d.aw_got = 1'b1;
				s_d.waddr = s_axi_awaddr[17:2];
			end
			if (s_axi_wvalid && s_q.w_rdy) begin
				s_d.w_got = 1'b1;
				s_d.wdata = s_axi_wdata;
				s_d.wbyte = s_axi_wstrb[0];
			end
			if (s_q.aw_got && s_q.w_got) begin
				do_wr = 1'b1;
				s_d.aw_got = 1'b0;
				s_d.w_got = 1'b0;
				s_d.wst = mip_pkg::MIP_BRSP;
				s_d.bresp = (rd_byte(s_q, s_q.waddr) > 9'h0FF) ?
					mip_pkg::RESP_SLVERR : mip_pkg::RESP_OKAY;
			end
		end else if (s_axi_bready) begin
			s_d.wst = mip_pkg::MIP_IDLE;
		end
		// register writes, byte lane 0 only
		if (do_wr && s_q.wbyte) begin
			if (s_q.waddr == mip_pkg::ADDR_PRIO_A)
				s_d.prio_a = wb;
			else if (s_q.waddr == mip_pkg::ADDR_PRIO_B)
				s_d.prio_b = wb & mip_pkg::MASK_PRIO_B;
			else if (s_q.waddr == mip_pkg::ADDR_PRIO_C)
				s_d.prio_c = wb & mip_pkg::MASK_PRIO_C;
			else if (s_q.waddr == mip_pkg::ADDR_KEY_EDGE)
				s_d.key_edge = wb;
			else if (s_q.waddr == mip_pkg::ADDR_TB_EN ||
				s_q.waddr == mip_pkg::ADDR_SER_EN ||
				s_q.waddr == mip_pkg::ADDR_KEY_EN ||
				s_q.waddr == mip_pkg::ADDR_TLO_EN ||
				s_q.waddr == mip_pkg::ADDR_THI_EN)
				// replace only the bits of the addressed group
				s_d.enables = (s_q.enables & ~spread(8'hFF, s_q.waddr)) |
					spread(wb, s_q.waddr);
			else
				clr = spread(wb, s_q.waddr);
		end
		// ones clear, zeros keep, a new event wins
		s_d.flags = (s_q.flags & ~clr) | set_ev;
		// read channel
		if (s_q.rst == mip_pkg::MIP_IDLE) begin
			if (s_axi_arvalid && s_q.ar_rdy) begin
				s_d.rst = mip_pkg::MIP_RRSP;
				s_d.rdata = {24'h000000, rb[7:0]};
				s_d.rresp = rb[8] ? mip_pkg::RESP_SLVERR : mip_pkg::RESP_OKAY;
			end
		end else if (s_axi_rready) begin
			s_d.rst = mip_pkg::MIP_IDLE;
		end
		// request outputs
		s_d.level  = best_lvl;
		s_d.source = best_src;
		s_d.nmi    = s_q.wd_sync2; // level 4 path
		// handshake outputs registered from the next state
		s_d.aw_rdy = (s_d.wst == mip_pkg::MIP_IDLE) && !s_d.aw_got;
		s_d.w_rdy  = (s_d.wst == mip_pkg::MIP_IDLE) && !s_d.w_got;
		s_d.bv     = (s_d.wst == mip_pkg::MIP_BRSP);
		s_d.ar_rdy = (s_d.rst == mip_pkg::MIP_IDLE);
		s_d.rv     = (s_d.rst == mip_pkg::MIP_RRSP);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// reset clears flags, enables and levels
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = s_q.aw_rdy;
	assign s_axi_wready  = s_q.w_rdy;
	assign s_axi_bvalid  = s_q.bv;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = s_q.ar_rdy;
	assign s_axi_rvalid  = s_q.rv;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign irq_level_o   = s_q.level;
	assign irq_source_o  = s_q.source;
	assign nmi_o         = s_q.nmi;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	chk_flag_set: assert property (ce_i && |set_ev |=>
		(s_q.flags & $past(set_ev)) == $past(set_ev))
		else $error("event did not set its flag");
	chk_flag_hold: assert property (ce_i && !do_wr |=>
		(s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
		else $error("flag dropped without a clear");
	chk_zero_level: assert property (s_q.prio_a == 8'h00 &&
		s_q.prio_b == 8'h00 && s_q.prio_c == 8'h00 && ce_i |=>
		irq_level_o == 2'h0)
		else $error("level 0 raised a request");
	chk_key_edge: assert property (ce_i && key_fall[0] &&
		!s_q.key_edge[0] |=> s_q.flags[mip_pkg::SRC_KEY + 7])
		else $error("key 0 falling edge missed");
	chk_tb_fall: assert property (ce_i && s_q.tb_prev[0] &&
		!s_q.tb_sync2[0] |=> s_q.flags[mip_pkg::SRC_TB + 6])
		else $error("time base falling edge missed");
	chk_level_pend: assert property (ce_i && pend == '0 |=>
		irq_level_o == 2'h0 && irq_source_o == mip_pkg::SRC_NONE)
		else $error("request without a pending source");
	chk_win_pend: assert property (ce_i |=> irq_level_o == 2'h0 ||
		$past(pend[best_src]))
		else $error("winner not pending");
	chk_nmi_path: assert property (ce_i && s_q.wd_sync2 |=> nmi_o)
		else $error("watchdog request not passed");
	chk_set_wins: assert property (ce_i && (set_ev & clr) != '0 |=>
		(s_q.flags & $past(set_ev & clr)) == $past(set_ev & clr))
		else $error("clear beat a new event");
endmodule // mip_core

/* File: inc/mip_pkg.sv */
// constants for the interrupt flag, enable and priority block
package mip_pkg;
	// ----------------------------------------------------------------
	// register indices: each register is one aligned word on the bus,
	// so its byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_PRIO_A    = 16'hFF20;
	localparam logic [15:0] ADDR_PRIO_B    = 16'hFF21;
	localparam logic [15:0] ADDR_TB_EN     = 16'hFF22;
	localparam logic [15:0] ADDR_SER_EN    = 16'hFF23;
	localparam logic [15:0] ADDR_KEY_EN    = 16'hFF24;
	localparam logic [15:0] ADDR_TLO_EN    = 16'hFF25;
	localparam logic [15:0] ADDR_TB_FLG    = 16'hFF26;
	localparam logic [15:0] ADDR_SER_FLG   = 16'hFF27;
	localparam logic [15:0] ADDR_KEY_FLG   = 16'hFF28;
	localparam logic [15:0] ADDR_TLO_FLG   = 16'hFF29;
	localparam logic [15:0] ADDR_PRIO_C    = 16'hFF2A;
	localparam logic [15:0] ADDR_THI_EN    = 16'hFF2C;
	localparam logic [15:0] ADDR_THI_FLG   = 16'hFF2E;
	localparam logic [15:0] ADDR_KEY_EDGE  = 16'hFF30;

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  RESET_BYTE     = 8'h00;
	localparam logic [7:0]  MASK_TB        = 8'h7F;
	localparam logic [7:0]  MASK_SER       = 8'h3F;
	localparam logic [7:0]  MASK_PRIO_B    = 8'h3F;
	localparam logic [7:0]  MASK_PRIO_C    = 8'h0F;

	// ----------------------------------------------------------------
	// source numbering: index = position in the default order
	// ----------------------------------------------------------------
	localparam int          NUM_SRC        = 37;
	localparam int          SRC_KEY        = 0;
	localparam int          SRC_TLO        = 8;
	localparam int          SRC_SER0       = 16;
	localparam int          SRC_TB         = 19;
	localparam int          SRC_THI        = 26;
	localparam int          SRC_SER1       = 34;
	localparam logic [5:0]  SRC_NONE       = 6'h3F;

	// ----------------------------------------------------------------
	// axi responses
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// handshake state of the bus slave
	typedef enum logic [1:0] {
		MIP_IDLE = 2'b00,
		MIP_BRSP = 2'b01,
		MIP_RRSP = 2'b10
	} mip_bus_t;
endpackage

/* File: verification/mip_core_tb.sv */
// self-checking bench for the interrupt flag, enable, priority block
`timescale 1ns/100ps
module mip_core_tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clock_i, rst_i, wd, ret, nmi, ce;
	logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [7:0]  key, taken;
	logic [15:0] tev;
	logic [17:0] awa, ara;
	logic [5:0]  sev, src;
	logic [6:0]  tick;
	logic [31:0] wdat, rdat, d;
	logic [3:0]  wstb;
	logic [1:0]  bresp, rresp, lvl, mask, r;
	int          n_errors = 0;
	int          checked = 0;
	logic [15:0] rw_a [8] = '{mip_pkg::ADDR_PRIO_A, mip_pkg::ADDR_PRIO_B,
		mip_pkg::ADDR_TB_EN, mip_pkg::ADDR_SER_EN, mip_pkg::ADDR_KEY_EN,
		mip_pkg::ADDR_TLO_EN, mip_pkg::ADDR_PRIO_C, mip_pkg::ADDR_THI_EN};
	logic [7:0]  rw_m [8] = '{8'hFF, 8'h3F, 8'h7F, 8'h3F, 8'hFF, 8'hFF,
		8'h0F, 8'hFF};
	logic [15:0] fa [6] = '{mip_pkg::ADDR_TB_FLG, mip_pkg::ADDR_SER_FLG,
		mip_pkg::ADDR_KEY_FLG, mip_pkg::ADDR_TLO_FLG, mip_pkg::ADDR_THI_FLG,
		mip_pkg::ADDR_KEY_EDGE};

	// ----------------------------------------------------------------
	// design and cpu model
	// ----------------------------------------------------------------
	mip_core DUT (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
		.key_pin_i(key), .timer_event_i(tev), .serial_event_i(sev),
		.timebase_tick_i(tick), .watchdog_i(wd),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wdat),
		.s_axi_wstrb(wstb), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.irq_level_o(lvl), .irq_source_o(src), .nmi_o(nmi));
	mip_cpu_model cpu (.clock_i(clock_i), .rst_i(rst_i), .level_i(lvl),
		.nmi_i(nmi), .ret_i(ret), .mask_o(mask), .taken_o(taken));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// verdict and end of run
	task automatic tally_and_finish;
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// compare one value
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// bound on every handshake wait
	task automatic hang(inout int n);
		n++;
		if (n > 50) begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	// axi4-lite write: address and data offered together
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v,
		output logic [1:0] rs);
		bit ad, dd;
		int n;
		ad = 1'b0;
		dd = 1'b0;
		n = 0;
		@(posedge clock_i);
		awv <= 1'b1;
		awa <= {a, 2'b00}; // byte address of the word index
		wv <= 1'b1;
		wdat <= {24'h000000, v};
		while (!(ad && dd)) begin
			@(posedge clock_i);
			if (!ad && awr) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (!dd && wr) begin
				dd = 1'b1;
				wv <= 1'b0;
			end
			hang(n);
		end
		br <= 1'b1;
		do begin
			@(posedge clock_i);
			hang(n);
		end while (!bv);
		rs = bresp;
		br <= 1'b0;
	endtask

	// axi4-lite read
	task automatic rd_reg(input logic [15:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clock_i);
		arv <= 1'b1;
		ara <= {a, 2'b00}; // byte address of the word index
		do begin
			@(posedge clock_i);
			hang(n);
		end while (!arr);
		arv <= 1'b0;
		rr <= 1'b1;
		do begin
			@(posedge clock_i);
			hang(n);
		end while (!rv);
		v = rdat;
		rs = rresp;
		rr <= 1'b0;
	endtask

	task automatic wchk(input logic [15:0] a, input logic [7:0] v);
		wr_reg(a, v, r);
		cmp($sformatf("wresp %h", a), 32'h0, {30'h0, r});
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		rd_reg(a, d, r);
		cmp($sformatf("rresp %h", a), 32'h0, {30'h0, r});
		cmp($sformatf("reg %h", a), {24'h000000, e}, d);
	endtask

	// one-cycle event pulses, then let the flags settle
	task automatic pulse(input logic [15:0] t, input logic [5:0] s);
		@(posedge clock_i);
		tev <= t;
		sev <= s;
		@(posedge clock_i);
		tev <= 16'h0000;
		sev <= 6'h00;
		cyc(3);
	endtask

	task automatic irq_chk(input logic [1:0] l, input logic [5:0] s);
		cyc(4);
		cmp("irq level", {30'h0, l}, {30'h0, lvl});
		cmp("irq source", {26'h0, s}, {26'h0, src});
	endtask

	task automatic cpu_chk(input logic [1:0] m, input logic [7:0] t);
		cmp("cpu mask", {30'h0, m}, {30'h0, mask});
		cmp("accepted", {24'h0, t}, {24'h0, taken});
	endtask

	task automatic ret_pulse;
		@(posedge clock_i);
		ret <= 1'b1;
		@(posedge clock_i);
		ret <= 1'b0;
		cyc(4);
	endtask

	// ----------------------------------------------------------------
	// clock and main sequence
	// ----------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	initial begin
		{rst_i, wd, ret, awv, wv, br, arv, rr} = 8'hFF & 8'h80;
		{key, tev, sev, tick, awa, ara, wdat} = '0;
		wstb = 4'hF;
		ce = 1'b1;
		cyc(16);
		rst_i <= 1'b0;
		cyc(2);
		// reset values
		for (int i = 0; i < 8; i++) rchk(rw_a[i], 8'h00);
		for (int i = 0; i < 6; i++) rchk(fa[i], 8'h00);
		irq_chk(2'h0, mip_pkg::SRC_NONE);
		// unmapped place refused
		wr_reg(16'hFF2B, 8'hFF, r);
		cmp("unmapped wresp", 32'h2, {30'h0, r});
		rd_reg(16'hFF2B, d, r);
		cmp("unmapped rresp", 32'h2, {30'h0, r});
		cmp("unmapped data", 32'h0, d);
		// byte lane 0 not strobed: no write
		wstb <= 4'hE;
		wchk(mip_pkg::ADDR_PRIO_A, 8'hFF);
		wstb <= 4'hF;
		rchk(mip_pkg::ADDR_PRIO_A, 8'h00);
		// writable bits of enables and priorities
		for (int i = 0; i < 8; i++) begin
			wchk(rw_a[i], 8'hFF);
			rchk(rw_a[i], rw_m[i]);
			wchk(rw_a[i], 8'h00);
		end
		// timer and serial flags, write-one clear
		pulse(16'h0422, 6'h2A);
		rchk(mip_pkg::ADDR_TLO_FLG, 8'h22);
		rchk(mip_pkg::ADDR_THI_FLG, 8'h04);
		rchk(mip_pkg::ADDR_SER_FLG, 8'h2A);
		wchk(mip_pkg::ADDR_TLO_FLG, 8'h00);
		rchk(mip_pkg::ADDR_TLO_FLG, 8'h22);
		wchk(mip_pkg::ADDR_TLO_FLG, 8'h20);
		rchk(mip_pkg::ADDR_TLO_FLG, 8'h02);
		wchk(mip_pkg::ADDR_THI_FLG, 8'hFF);
		wchk(mip_pkg::ADDR_SER_FLG, 8'h2B);
		rchk(mip_pkg::ADDR_SER_FLG, 8'h00);
		// time base: rising edges ignored, falling edges set
		tick <= 7'h7F;
		cyc(6);
		rchk(mip_pkg::ADDR_TB_FLG, 8'h00);
		tick <= 7'h41;
		cyc(6);
		rchk(mip_pkg::ADDR_TB_FLG, 8'h3E);
		// keys: key 3 rising, key 2 falling
		wchk(mip_pkg::ADDR_KEY_EDGE, 8'h08);
		key <= 8'h0C;
		cyc(6);
		rchk(mip_pkg::ADDR_KEY_FLG, 8'h08);
		key <= 8'h00;
		cyc(6);
		rchk(mip_pkg::ADDR_KEY_FLG, 8'h0C);
		// priority: timer0 match (9) against serial0 transmit (18)
		pulse(16'h0000, 6'h01);
		wchk(mip_pkg::ADDR_TLO_EN, 8'h02);
		wchk(mip_pkg::ADDR_SER_EN, 8'h01);
		irq_chk(2'h0, mip_pkg::SRC_NONE);
		wchk(mip_pkg::ADDR_PRIO_B, 8'h04);
		irq_chk(2'h1, 6'h09);
		cpu_chk(2'h1, 8'h01);
		wchk(mip_pkg::ADDR_PRIO_A, 8'h20);
		irq_chk(2'h2, 6'h12);
		cpu_chk(2'h2, 8'h02);
		wchk(mip_pkg::ADDR_PRIO_B, 8'h08);
		irq_chk(2'h2, 6'h09);
		ret_pulse();
		cpu_chk(2'h2, 8'h03);
		wchk(mip_pkg::ADDR_TLO_FLG, 8'h02);
		irq_chk(2'h2, 6'h12);
		wchk(mip_pkg::ADDR_SER_FLG, 8'h01);
		irq_chk(2'h0, mip_pkg::SRC_NONE);
		ret_pulse();
		ret_pulse();
		cpu_chk(2'h0, 8'h03);
		// watchdog request
		wd <= 1'b1;
		cyc(6);
		cmp("nmi", 32'h1, {31'h0, nmi});
		cpu_chk(2'h3, 8'h04);
		wd <= 1'b0;
		cyc(4);
		// clock enable low: an event pulse must leave no flag
		ce <= 1'b0;
		pulse(16'h0001, 6'h00);
		ce <= 1'b1;
		rchk(mip_pkg::ADDR_TLO_FLG, 8'h00);
		// second reset in mid-run clears flags, enables, priorities
		rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		cyc(2);
		rchk(mip_pkg::ADDR_TB_FLG, 8'h00);
		rchk(mip_pkg::ADDR_PRIO_B, 8'h00);
		rchk(mip_pkg::ADDR_TLO_EN, 8'h00);
		irq_chk(2'h0, mip_pkg::SRC_NONE);
		tally_and_finish();
	end
endmodule // mip_core_tb

/* File: verification/mip_cpu_model.sv */
// cpu core model: masks, accepts and returns from requests
`timescale 1ns/100ps
module mip_cpu_model (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	// requests from the block, return strobe
	input  wire logic [1:0] level_i,
	input  wire logic       nmi_i,
	input  wire logic       ret_i,
	// mask and count of accepted requests
	output logic      [1:0] mask_o,
	output logic      [7:0] taken_o
);
	logic [1:0] stack_q [4];
	logic [1:0] sp_q;
	logic       nmi_q;

	// every cycle counts as an opcode fetch sample
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mask_o  <= 2'h0;
			taken_o <= 8'h00;
			sp_q    <= 2'h0;
			nmi_q   <= 1'b0;
		end else begin
			nmi_q <= nmi_i;
			if (nmi_i && !nmi_q) begin
				// watchdog taken whatever the mask
				stack_q[sp_q] <= mask_o;
				sp_q          <= sp_q + 2'h1;
				mask_o        <= 2'h3;
				taken_o       <= taken_o + 8'h01;
			end else if (level_i > mask_o) begin
				// only levels above the mask
				stack_q[sp_q] <= mask_o;
				sp_q          <= sp_q + 2'h1;
				mask_o        <= level_i;
				taken_o       <= taken_o + 8'h01;
			end else if (ret_i) begin
				// mask back to its value before acceptance
				sp_q   <= sp_q - 2'h1;
				mask_o <= stack_q[sp_q - 2'h1];
			end
		end
	end
endmodule // mip_cpu_model
